//--- src/can_mailbox_message_store.v
// Mailbox control and payload store with AXI4-Lite and engine ports
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
// ==========================================================
// Overview of operation
// - Sixteen mailboxes each hold eight byte-wide control locations.
// - Control storage is RAM with no reset; software fills it first.
// - Control byte 1 bits 3:0 give the length, codes above 8 mean 8.
// - Control byte 5 bit 4 marks a remote frame when set.
// - Control byte 5 bit 3 marks the extended 29-bit identifier format.
// - Control byte 5 holds identifier bits 20:18 in 7:5 and 17:16 in 1:0.
// - Control byte 6 holds identifier bits 28:21.
// - Control byte 7 holds identifier bits 7:0, extended frames only.
// - Control byte 8 holds identifier bits 15:8, extended frames only.
// - Each mailbox also holds eight byte-wide payload locations.
// - Payload storage is RAM with no reset; software fills it first.
// - Mailbox 0 only receives and 1 to 15 start as transmit.
`include "mbox_store_regs.vh"

module can_mailbox_message_store (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire eng_rd,
  input wire eng_wr,
  input wire [3:0] eng_mbox,
  input wire [28:0] eng_wid,
  input wire eng_wide,
  input wire eng_wrtr,
  input wire [3:0] eng_wdlc,
  input wire [63:0] eng_wdata,
  output reg eng_rvalid,
  output reg [28:0] eng_id,
  output reg eng_ide,
  output reg eng_rtr,
  output reg [3:0] eng_len,
  output reg [63:0] eng_data,
  output reg eng_is_rx,
  output reg eng_wack,
  output reg eng_wfail
);

  // ========================================================
  // Storage
  // Deliberately no reset on ctl_mem and dat_mem: contents are undefined until written
  reg [63:0] ctl_mem [0:15];
  reg [63:0] dat_mem [0:15];
  reg [15:0] dir_q;

  // ========================================================
  // Write channel
  reg [11:0] aw_addr_q;
  reg aw_have_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg w_have_q;
  wire bus_we;
  wire w_in_mbox;
  wire w_is_dir;
  wire [3:0] w_mb;
  wire [2:0] w_bi;

  assign bus_we = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign w_in_mbox =
    (aw_addr_q[`REGION_HI:`REGION_LO] == `MBOX_REGION);
  assign w_is_dir =
    ({aw_addr_q[`REGION_HI:`BYTE_LO], 2'b00} == `DIR_CFG_ADDR);
  assign w_mb = aw_addr_q[`MBOX_HI:`MBOX_LO];
  assign w_bi = aw_addr_q[`BYTE_HI:`BYTE_LO];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (bus_we) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (w_in_mbox | w_is_dir) ? `RESP_OKAY
                                               : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ========================================================
  // Direction configuration
  // Only the hard reset loads it with 16'h0001; no soft reset path reaches here
  always @(posedge aclk) begin
    if (!aresetn) begin
      dir_q <= `DIR_RESET;
    end else if (bus_we && w_is_dir) begin
      if (w_strb_q[0])
        dir_q[7:1] <= w_data_q[7:1];
      if (w_strb_q[1])
        dir_q[15:8] <= w_data_q[15:8];
      dir_q[`RX_ONLY_MBOX] <= 1'b1;
    end
  end

  // ========================================================
  // Engine side
  wire eng_we_ok;
  wire [63:0] ctl_sel;
  wire [63:0] dat_sel;
  wire [3:0] dlc_sel;
  wire [63:0] data_bus_order;

  assign eng_we_ok = eng_wr & dir_q[eng_mbox];
  assign ctl_sel = ctl_mem[eng_mbox];
  assign dat_sel = dat_mem[eng_mbox];
  assign dlc_sel = ctl_sel[`DLC_HI:`DLC_LO];

  // Byte 1 leaves first, so it sits at the top of the engine word
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_order
      assign data_bus_order[63 - 8 * g -: 8] =
        dat_sel[8 * g +: 8];
    end
  endgenerate

  // ========================================================
  // Memory writes
  // Engine writes come last so they win a same-cycle collision
  always @(posedge aclk) begin
    if (bus_we && w_in_mbox && w_strb_q[0]) begin
      if (aw_addr_q[`SEL_BIT])
        dat_mem[w_mb][8 * w_bi +: 8] <= w_data_q[7:0];
      else
        ctl_mem[w_mb][8 * w_bi +: 8] <= w_data_q[7:0];
    end
    if (eng_we_ok) begin
      ctl_mem[eng_mbox][`DLC_HI:`DLC_LO] <= eng_wdlc;
      ctl_mem[eng_mbox][`RTR_BIT] <= eng_wrtr;
      ctl_mem[eng_mbox][`IDE_BIT] <= eng_wide;
      ctl_mem[eng_mbox][`ID20_18_HI:`ID20_18_LO] <=
        eng_wid[20:18];
      ctl_mem[eng_mbox][`ID28_21_HI:`ID28_21_LO] <=
        eng_wid[28:21];
      if (eng_wide) begin
        ctl_mem[eng_mbox][`ID17_16_HI:`ID17_16_LO] <=
          eng_wid[17:16];
        ctl_mem[eng_mbox][`ID7_0_HI:`ID7_0_LO] <=
          eng_wid[7:0];
        ctl_mem[eng_mbox][`ID15_8_HI:`ID15_8_LO] <=
          eng_wid[15:8];
      end
      dat_mem[eng_mbox] <= {eng_wdata[7:0], eng_wdata[15:8],
        eng_wdata[23:16], eng_wdata[31:24], eng_wdata[39:32],
        eng_wdata[47:40], eng_wdata[55:48], eng_wdata[63:56]};
    end
  end

  // ========================================================
  // Engine answers
  always @(posedge aclk) begin
    if (!aresetn) begin
      eng_rvalid <= 1'b0;
      eng_id <= 29'h0000000;
      eng_ide <= 1'b0;
      eng_rtr <= 1'b0;
      eng_len <= 4'h0;
      eng_data <= 64'h0000000000000000;
      eng_is_rx <= 1'b0;
      eng_wack <= 1'b0;
      eng_wfail <= 1'b0;
    end else begin
      eng_rvalid <= eng_rd;
      eng_wack <= eng_wr;
      eng_wfail <= eng_wr & ~eng_we_ok;
      if (eng_rd) begin
        eng_is_rx <= dir_q[eng_mbox];
        eng_rtr <= ctl_sel[`RTR_BIT];
        eng_ide <= ctl_sel[`IDE_BIT];
        eng_len <= dlc_sel[3] ? `DLC_MAX : dlc_sel;
        eng_data <= data_bus_order;
        eng_id[28:21] <= ctl_sel[`ID28_21_HI:`ID28_21_LO];
        eng_id[20:18] <= ctl_sel[`ID20_18_HI:`ID20_18_LO];
        if (ctl_sel[`IDE_BIT]) begin
          eng_id[17:16] <= ctl_sel[`ID17_16_HI:`ID17_16_LO];
          eng_id[15:8] <= ctl_sel[`ID15_8_HI:`ID15_8_LO];
          eng_id[7:0] <= ctl_sel[`ID7_0_HI:`ID7_0_LO];
        end else begin
          eng_id[17:0] <= 18'h0;
        end
      end
    end
  end

  // ========================================================
  // Read channel
  wire r_in_mbox;
  wire r_is_dir;
  wire [3:0] r_mb;
  wire [2:0] r_bi;
  wire [63:0] r_ctl;
  wire [63:0] r_dat;
  wire [7:0] r_byte;

  assign r_in_mbox =
    (s_axi_araddr[`REGION_HI:`REGION_LO] == `MBOX_REGION);
  assign r_is_dir =
    ({s_axi_araddr[`REGION_HI:`BYTE_LO], 2'b00} == `DIR_CFG_ADDR);
  assign r_mb = s_axi_araddr[`MBOX_HI:`MBOX_LO];
  assign r_bi = s_axi_araddr[`BYTE_HI:`BYTE_LO];
  assign r_ctl = ctl_mem[r_mb];
  assign r_dat = dat_mem[r_mb];
  assign r_byte = s_axi_araddr[`SEL_BIT] ? r_dat[8 * r_bi +: 8]
                                         : r_ctl[8 * r_bi +: 8];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        if (r_in_mbox)
          s_axi_rdata <= {24'h000000, r_byte};
        else if (r_is_dir)
          s_axi_rdata <= {16'h0000, dir_q};
        else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

//--- src/mbox_store_regs.vh
// Address map, field positions and reset values of the mailbox store
`ifndef MBOX_STORE_REGS_VH
`define MBOX_STORE_REGS_VH

// ==========================================================
// Bus address map
`define ADDR_W 12
`define MBOX_REGION 2'b00
`define REGION_HI 11
`define REGION_LO 10
`define MBOX_HI 9
`define MBOX_LO 6
`define SEL_BIT 5
`define BYTE_HI 4
`define BYTE_LO 2
`define DIR_CFG_ADDR 12'h400

// ==========================================================
// Control byte indices (byte k lives at index k-1)
`define LEN_BYTE 3'h0
`define SPARE2_BYTE 3'h1
`define SPARE3_BYTE 3'h2
`define SPARE4_BYTE 3'h3
`define FLAGS_BYTE 3'h4
`define ID_TOP_BYTE 3'h5
`define ID_LOW_BYTE 3'h6
`define ID_LMID_BYTE 3'h7

// ==========================================================
// Field positions inside the 64-bit control word
`define DLC_HI 3
`define DLC_LO 0
`define RTR_BIT 36
`define IDE_BIT 35
`define ID20_18_HI 39
`define ID20_18_LO 37
`define ID17_16_HI 33
`define ID17_16_LO 32
`define ID28_21_HI 47
`define ID28_21_LO 40
`define ID7_0_HI 55
`define ID7_0_LO 48
`define ID15_8_HI 63
`define ID15_8_LO 56

// ==========================================================
// Length codes, reset values, responses
`define DLC_MAX 4'h8
`define DIR_RESET 16'h0001
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define RX_ONLY_MBOX 4'h0

`endif

//--- bench/engine_model.sv
// Behavioural protocol engine on the store's engine port
`timescale 1ns/1ns
module engine_model (
  input wire aclk,
  output reg eng_rd,
  output reg eng_wr,
  output reg [3:0] eng_mbox,
  output reg [28:0] eng_wid,
  output reg eng_wide,
  output reg eng_wrtr,
  output reg [3:0] eng_wdlc,
  output reg [63:0] eng_wdata
);
  initial begin
    {eng_rd, eng_wr, eng_mbox, eng_wid} = '0;
    {eng_wide, eng_wrtr, eng_wdlc, eng_wdata} = '0;
  end

  // ====
  // Requests, one cycle each
  task rd(input logic [3:0] m);
    eng_mbox <= m;
    eng_rd <= 1'b1;
    @(posedge aclk);
    eng_rd <= 1'b0;
    eng_mbox <= ~m;
  endtask

  task wr(input logic [3:0] m, input logic [28:0] i, input logic x,
          input logic r, input logic [3:0] l, input logic [63:0] d);
    eng_mbox <= m;
    eng_wid <= i;
    eng_wide <= x;
    eng_wrtr <= r;
    eng_wdlc <= l;
    eng_wdata <= d;
    eng_wr <= 1'b1;
    @(posedge aclk);
    eng_wr <= 1'b0;
    // Stale lines must not look valid
    eng_wid <= ~i;
    eng_wdata <= ~d;
  endtask
endmodule

//--- bench/mbox_store_properties.sv
// Assertions on the engine port of the mailbox store
`timescale 1ns/1ns
module mbox_store_checker (
  input wire aclk,
  input wire aresetn,
  input wire eng_rd,
  input wire eng_wr,
  input wire [3:0] eng_mbox,
  input wire eng_rvalid,
  input wire [28:0] eng_id,
  input wire eng_ide,
  input wire [3:0] eng_len,
  input wire [63:0] eng_data,
  input wire eng_is_rx,
  input wire eng_wack,
  input wire eng_wfail
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ====
  // Engine reads and stores
  sequence s_take;
    eng_rd ##1 eng_rvalid;
  endsequence
  sequence s_rd0;
    eng_rd && eng_mbox == 4'h0;
  endsequence

  a_rd_answer: assert property (eng_rd |-> s_take)
    else $error("engine read not answered");
  a_rd_quiet: assert property (!eng_rd |=> !eng_rvalid)
    else $error("read valid without request");
  a_out_hold: assert property (!eng_rd |=> $stable(eng_data)
    && $stable(eng_id)) else $error("read outputs moved");
  a_wr_answer: assert property (eng_wr |=> eng_wack)
    else $error("engine store not acknowledged");
  a_fail_pair: assert property (eng_wfail |-> eng_wack)
    else $error("refusal without acknowledge");
  a_len_clamp: assert property (eng_rvalid |-> eng_len <= 4'h8)
    else $error("length above eight");
  a_std_id: assert property (eng_rvalid && !eng_ide
    |-> eng_id[17:0] == 18'h0) else $error("standard id low bits set");
  a_rx_only: assert property (s_rd0 |=> eng_is_rx)
    else $error("mailbox zero not receive");
endmodule

bind can_mailbox_message_store mbox_store_checker u_mbox_store_checker (
  .aclk(aclk),
  .aresetn(aresetn),
  .eng_rd(eng_rd),
  .eng_wr(eng_wr),
  .eng_mbox(eng_mbox),
  .eng_rvalid(eng_rvalid),
  .eng_id(eng_id),
  .eng_ide(eng_ide),
  .eng_len(eng_len),
  .eng_data(eng_data),
  .eng_is_rx(eng_is_rx),
  .eng_wack(eng_wack),
  .eng_wfail(eng_wfail)
);

//--- bench/tb_can_mailbox_message_store.sv
// Self-checking testbench for the mailbox store
`timescale 1ns/1ns
module tb_can_mailbox_message_store;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  // Ready held high: every answer is taken as it comes
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] rs;
  wire s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid;
  wire s_axi_rvalid, eng_rd, eng_wr, eng_wide, eng_wrtr, eng_rvalid;
  wire eng_ide, eng_rtr, eng_is_rx, eng_wack, eng_wfail;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] eng_mbox, eng_wdlc, eng_len;
  wire [28:0] eng_wid, eng_id;
  wire [63:0] eng_wdata, eng_data;
  int n_mismatch = 0, n_tests = 0, cyc = 0;

  can_mailbox_message_store u_can_mailbox_message_store (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .eng_rd(eng_rd),
    .eng_wr(eng_wr),
    .eng_mbox(eng_mbox),
    .eng_wid(eng_wid),
    .eng_wide(eng_wide),
    .eng_wrtr(eng_wrtr),
    .eng_wdlc(eng_wdlc),
    .eng_wdata(eng_wdata),
    .eng_rvalid(eng_rvalid),
    .eng_id(eng_id),
    .eng_ide(eng_ide),
    .eng_rtr(eng_rtr),
    .eng_len(eng_len),
    .eng_data(eng_data),
    .eng_is_rx(eng_is_rx),
    .eng_wack(eng_wack),
    .eng_wfail(eng_wfail)
  );
  engine_model u_engine_model (
    .aclk(aclk),
    .eng_rd(eng_rd),
    .eng_wr(eng_wr),
    .eng_mbox(eng_mbox),
    .eng_wid(eng_wid),
    .eng_wide(eng_wide),
    .eng_wrtr(eng_wrtr),
    .eng_wdlc(eng_wdlc),
    .eng_wdata(eng_wdata)
  );

  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ====
  // Shared tasks
  task finish_test();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask

  function automatic logic [11:0] ad(input int m, input int k);
    return 12'(m * 64 + k * 4);
  endfunction

  task bw(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
  endtask

  task br(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask

  task erd(input logic [3:0] m);
    u_engine_model.rd(m);
    #1;
    chk(eng_rvalid, 1'b1);
    @(posedge aclk);
  endtask

  task ewr(input logic [3:0] m, input logic [28:0] i, input logic x,
           input logic r, input logic [3:0] l, input logic [63:0] d,
           input logic f);
    u_engine_model.wr(m, i, x, r, l, d);
    #1;
    chk({eng_wack, eng_wfail}, {1'b1, f});
    @(posedge aclk);
  endtask

  // ====
  // Scenarios
  task t_bus;
    for (int m = 0; m < 16; m++)
      for (int k = 0; k < 16; k++) begin
        bw(ad(m, k), 32'(m * 16 + k));
        chk(rs, 2'b00);
        br(ad(m, k));
        chk(rd, 32'(m * 16 + k));
      end
    br(12'h400);
    chk(rd, 32'h1);
    br(12'h800);
    chk({rs, rd}, {2'b10, 32'h0});
    bw(12'h800, 32'h5a);
    chk(rs, 2'b10);
    // Byte lane 0 off: the stored byte must not change
    s_axi_wstrb <= 4'h0;
    bw(ad(0, 0), 32'hff);
    s_axi_wstrb <= 4'hf;
    br(ad(0, 0));
    chk(rd, 32'h0);
    bw(12'h400, 32'h20);
    br(12'h400);
    chk(rd, 32'h21);
    erd(4'h0);
    chk(eng_is_rx, 1'b1);
    $display("t_bus done");
  endtask

  task t_frame;
    logic [63:0] pl;
    pl = 64'h1122334455667788;
    bw(ad(3, 4), 32'hba);
    bw(ad(3, 5), 32'hab);
    bw(ad(3, 6), 32'h12);
    bw(ad(3, 7), 32'h34);
    for (int k = 0; k < 8; k++)
      bw(ad(3, k + 8), 32'(pl[63 - 8 * k -: 8]));
    for (int c = 0; c < 16; c++) begin
      bw(ad(3, 0), 32'(c));
      erd(4'h3);
      chk(eng_len, (c > 8) ? 64'h8 : 64'(c));
    end
    chk(eng_id, {8'hab, 3'b101, 2'b10, 8'h34, 8'h12});
    chk({eng_rtr, eng_ide, eng_is_rx}, 3'b110);
    chk(eng_data, pl);
    bw(ad(3, 4), 32'ha2);
    erd(4'h3);
    chk(eng_id, {8'hab, 3'b101, 18'h0});
    chk({eng_rtr, eng_ide}, 2'b00);
    // Mailbox 3 transmits, so the store is refused
    ewr(4'h3, 29'h0, 1'b0, 1'b0, 4'h1, 64'h0, 1'b1);
    erd(4'h3);
    chk(eng_data, pl);
    $display("t_frame done");
  endtask

  task t_store;
    ewr(4'h5, 29'h1bcdef12, 1'b1, 1'b1, 4'h6, 64'h0102030405060708, 1'b0);
    erd(4'h5);
    chk(eng_id, 29'h1bcdef12);
    chk({eng_rtr, eng_ide, eng_len, eng_is_rx}, 7'h6d);
    chk(eng_data, 64'h0102030405060708);
    ewr(4'h5, 29'h1bcdef12, 1'b0, 1'b0, 4'h9, 64'h0, 1'b0);
    erd(4'h5);
    chk({eng_id, eng_ide, eng_len}, {29'h1bcc0000, 5'h08});
    $display("t_store done");
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_bus();
    t_frame();
    t_store();
    finish_test();
  end
endmodule
